/* logic/pecnt_defines.svh */
/*
 * constant names for the error counter and 10 Mb/s control register group.
 * assumes: included by bare name from logic files; holds definitions only.
 */
`ifndef PECNT_DEFINES_SVH
`define PECNT_DEFINES_SVH

// ****************************************
// register indices
// ****************************************
`define PECNT_IDX_RX_ERR 5'h13
`define PECNT_IDX_FALSE_CARRIER 5'h14
`define PECNT_IDX_LINK_DROP 5'h15
`define PECNT_IDX_TEN_CTRL 5'h16
`define PECNT_IDX_EXT_CTRL1 5'h17
`define PECNT_IDX_IRQ_STATUS 5'h1C
`define PECNT_IDX_IRQ_MASK 5'h1D

// ****************************************
// field positions
// ****************************************
`define PECNT_BIT_LINK_INT_DIS 15
`define PECNT_BIT_JABBER_DIS 14
`define PECNT_BIT_ECHO_DIS 13
`define PECNT_BIT_SQE_DIS 12
`define PECNT_SQUELCH_HI 11
`define PECNT_SQUELCH_LO 10
`define PECNT_CRS_SEL_HI 2
`define PECNT_CRS_SEL_LO 1
`define PECNT_BIT_FAR_LOOP 3
`define PECNT_CNT_W 8
`define PECNT_ADDR_W 5
`define PECNT_DATA_W 16
`define PECNT_IRQ_W 3

// ****************************************
// reset values and limits
// ****************************************
`define PECNT_CNT_MAX 8'hFF
`define PECNT_CNT_ONE 8'h01
`define PECNT_CNT_ZERO 8'h00
`define PECNT_TEN_CTRL_RST 16'h3000
`define PECNT_TEN_CTRL_WMASK 16'hFC06
`define PECNT_EXT_CTRL1_WMASK 16'h0008
`define PECNT_IRQ_ZERO 3'h0

`endif

/* logic/pecnt_pkg.sv */
/*
 * types for the error counter and 10 Mb/s control register group.
 * assumes: compiled before the modules that use it.
 */
package pecnt_pkg;

    typedef enum logic [1:0] {
        PECNT_SQ_NOMINAL = 2'h0,
        PECNT_SQ_REDUCED = 2'h1,
        PECNT_SQ_RAISED = 2'h2,
        PECNT_SQ_RESERVED = 2'h3
    } pecnt_squelch_t;

    typedef enum logic [1:0] {
        PECNT_CRS_RX_OR_TXHD = 2'h0,
        PECNT_CRS_ANY_HD = 2'h1,
        PECNT_CRS_RX = 2'h2,
        PECNT_CRS_RX_HD = 2'h3
    } pecnt_crs_sel_t;

    typedef enum logic [2:0] {
        PECNT_ST_IDLE = 3'h1,
        PECNT_ST_READ = 3'h2,
        PECNT_ST_WRITE = 3'h4
    } pecnt_bus_st_t;

endpackage

/* logic/pecnt_sat_counter.sv */
/*
 * saturating event counter that clears when read.
 * assumes: single clock; event and clear are synchronous pulses.
 */
`include "pecnt_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module pecnt_sat_counter #(
    parameter int WIDTH = `PECNT_CNT_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // control
    input wire logic count_event,
    input wire logic clear,
    // state
    output logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    wire at_max = (count_reg == {WIDTH{1'b1}});
    wire [WIDTH-1:0] count_inc = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};

    // read clear with coincident event leaves one
    assign count_next = clear ? {{(WIDTH-1){1'b0}}, count_event}
        : (count_event && !at_max) ? count_inc : count_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            count_reg <= '0;
        else if (clk_en)
            count_reg <= count_next;
    end

    assign count = count_reg;

    property p_saturate;
        @(posedge mclk) disable iff (rst)
        (clk_en && at_max && !clear) |=> at_max;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("counter left its saturated value");

    property p_clear_keeps_event;
        @(posedge mclk) disable iff (rst)
        (clk_en && clear) |=> (count_reg == {{(WIDTH-1){1'b0}},
            $past(count_event)});
    endproperty
    a_clear_keeps_event: assert property (p_clear_keeps_event)
        else $error("clear did not leave event count");

endmodule

`default_nettype wire

/* logic/pecnt_sync2.sv */
/*
 * two flip-flop synchroniser for a bundle of level inputs.
 * assumes: inputs are asynchronous to mclk.
 */
`timescale 1ns/100ps
`default_nettype none

module pecnt_sync2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

/* logic/pecnt_top.sv */
/*
 * PHY error counters, 10 Mb/s extended control and far-end loopback enable,
 * with a small interrupt status/mask pair for the counted events.
 * assumes: PHY core status arrives as asynchronous levels/toggles on pins;
 * management master uses the plain strobe port on mclk.
 */
// Contract
// - An 8-bit receive error count grows on 100M/1000M receive errors only while that link is up.
// - An 8-bit false carrier count grows on 100M/1000M false carriers only while that link is up.
// - Each count sticks at 255 and a read returns it then zeroes it, or leaves 1 if an event lands in the read cycle.
// - An 8-bit link drop count grows each time the copper link goes down at any speed.
// - Control bit 15 set disables the 10M link-integrity machine; resets to 0.
// - Control bit 14 set disables 10M jabber detection; resets to 0.
// - Control bit 13 set disables 10M echo; resets to 1.
// - Control bit 12 set disables the 10M SQE test; resets to 1.
// - Control bits 11:10 pick the squelch threshold, 00 nominal 01 reduced 10 raised 11 reserved.
// - Control bits 2:1 choose how carrier sense is derived from receive, transmit and duplex.
// - Extended control bit 3 enables far-end loopback, resets to 0, other bits read-only.
`include "pecnt_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module pecnt_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // register port
    input wire logic [`PECNT_ADDR_W-1:0] reg_addr,
    input wire logic [`PECNT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PECNT_DATA_W-1:0] reg_rdata,
    // phy core status, asynchronous
    input wire logic rx_err_toggle,
    input wire logic false_carrier_toggle,
    input wire logic link_up_100,
    input wire logic link_up_1000,
    input wire logic link_up_any,
    input wire logic receiving,
    input wire logic transmitting,
    input wire logic full_duplex_flag,
    // control to phy core
    output logic link_integrity_dis,
    output logic jabber_dis,
    output logic echo_dis,
    output logic sqe_test_dis,
    output logic [1:0] squelch_sel,
    output logic carrier_sense,
    output logic far_end_loopback,
    // interrupt
    output logic irq
);

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync_bus;

    pecnt_sync2 #(
        .WIDTH(NSYNC)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({rx_err_toggle, false_carrier_toggle, link_up_100,
            link_up_1000, link_up_any, receiving, transmitting,
            full_duplex_flag}),
        .sync_out(sync_bus)
    );

    wire s_rx_err_t = sync_bus[7];
    wire s_fc_t = sync_bus[6];
    wire s_up_100 = sync_bus[5];
    wire s_up_1000 = sync_bus[4];
    wire s_up_any = sync_bus[3];
    wire s_rxing = sync_bus[2];
    wire s_txing = sync_bus[1];
    wire s_fdx = sync_bus[0];

    // ****************************************
    // event detection
    // ****************************************
    logic rx_err_t_reg;
    logic fc_t_reg;
    logic up_any_reg;
    // marks sync and edge flops filled with real pin levels
    localparam int WARM = 3;
    logic [WARM-1:0] warm_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_err_t_reg <= 1'b0;
            fc_t_reg <= 1'b0;
            up_any_reg <= 1'b0;
            warm_reg <= '0;
        end
        else if (clk_en)
        begin
            rx_err_t_reg <= s_rx_err_t;
            fc_t_reg <= s_fc_t;
            up_any_reg <= s_up_any;
            warm_reg <= {warm_reg[WARM-2:0], 1'b1};
        end
    end

    wire fast_link_up = s_up_100 | s_up_1000;
    // toggle pin left high over reset is no event
    wire armed = warm_reg[WARM-1];
    wire ev_gate = fast_link_up & armed;
    wire rx_err_ev = (s_rx_err_t ^ rx_err_t_reg) & ev_gate;
    wire fc_ev = (s_fc_t ^ fc_t_reg) & ev_gate;
    wire drop_ev = up_any_reg & ~s_up_any;

    // ****************************************
    // address decode
    // ****************************************
    wire hit_rxe = (reg_addr == `PECNT_IDX_RX_ERR);
    wire hit_fc = (reg_addr == `PECNT_IDX_FALSE_CARRIER);
    wire hit_drop = (reg_addr == `PECNT_IDX_LINK_DROP);
    wire hit_ten = (reg_addr == `PECNT_IDX_TEN_CTRL);
    wire hit_ext = (reg_addr == `PECNT_IDX_EXT_CTRL1);
    wire hit_ist = (reg_addr == `PECNT_IDX_IRQ_STATUS);
    wire hit_imk = (reg_addr == `PECNT_IDX_IRQ_MASK);

    // ****************************************
    // counters
    // ****************************************
    logic [`PECNT_CNT_W-1:0] rxe_cnt;
    logic [`PECNT_CNT_W-1:0] fc_cnt;
    logic [`PECNT_CNT_W-1:0] drop_cnt;

    pecnt_sat_counter #(
        .WIDTH(`PECNT_CNT_W)
    ) u_rxe_cnt (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .count_event(rx_err_ev),
        .clear(reg_rd && hit_rxe),
        .count(rxe_cnt)
    );

    pecnt_sat_counter #(
        .WIDTH(`PECNT_CNT_W)
    ) u_fc_cnt (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .count_event(fc_ev),
        .clear(reg_rd && hit_fc),
        .count(fc_cnt)
    );

    pecnt_sat_counter #(
        .WIDTH(`PECNT_CNT_W)
    ) u_drop_cnt (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .count_event(drop_ev),
        .clear(reg_rd && hit_drop),
        .count(drop_cnt)
    );

    // ****************************************
    // control registers
    // ****************************************
    logic [`PECNT_DATA_W-1:0] ten_ctrl_reg;
    logic [`PECNT_DATA_W-1:0] ext_ctrl_reg;
    logic [`PECNT_IRQ_W-1:0] irq_stat_reg;
    logic [`PECNT_IRQ_W-1:0] irq_mask_reg;

    // only documented writable fields take writes
    wire [`PECNT_DATA_W-1:0] ten_ctrl_next =
        reg_wdata & `PECNT_TEN_CTRL_WMASK;
    wire [`PECNT_DATA_W-1:0] ext_ctrl_next =
        reg_wdata & `PECNT_EXT_CTRL1_WMASK;

    wire [`PECNT_IRQ_W-1:0] irq_events = {drop_ev, fc_ev, rx_err_ev};
    wire [`PECNT_IRQ_W-1:0] irq_w1c =
        (reg_wr && hit_ist) ? reg_wdata[`PECNT_IRQ_W-1:0] : `PECNT_IRQ_ZERO;
    // set wins over a coincident clear
    wire [`PECNT_IRQ_W-1:0] irq_stat_next =
        (irq_stat_reg & ~irq_w1c) | irq_events;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ten_ctrl_reg <= `PECNT_TEN_CTRL_RST;
            ext_ctrl_reg <= '0;
            irq_stat_reg <= `PECNT_IRQ_ZERO;
            irq_mask_reg <= `PECNT_IRQ_ZERO;
        end
        else if (clk_en)
        begin
            if (reg_wr && hit_ten)
                ten_ctrl_reg <= ten_ctrl_next;
            if (reg_wr && hit_ext)
                ext_ctrl_reg <= ext_ctrl_next;
            if (reg_wr && hit_imk)
                irq_mask_reg <= reg_wdata[`PECNT_IRQ_W-1:0];
            irq_stat_reg <= irq_stat_next;
        end
    end

    // ****************************************
    // carrier sense derivation
    // ****************************************
    logic crs_next;
    pecnt_pkg::pecnt_crs_sel_t crs_sel;

    assign crs_sel = pecnt_pkg::pecnt_crs_sel_t'(
        ten_ctrl_reg[`PECNT_CRS_SEL_HI:`PECNT_CRS_SEL_LO]);

    always_comb
    begin
        case (crs_sel)
            pecnt_pkg::PECNT_CRS_RX_OR_TXHD:
                crs_next = s_rxing | (s_txing & ~s_fdx);
            pecnt_pkg::PECNT_CRS_ANY_HD:
                crs_next = (s_rxing | s_txing) & ~s_fdx;
            pecnt_pkg::PECNT_CRS_RX:
                crs_next = s_rxing;
            pecnt_pkg::PECNT_CRS_RX_HD:
                crs_next = s_rxing & ~s_fdx;
            default:
                crs_next = s_rxing;
        endcase
    end

    // ****************************************
    // read mux
    // ****************************************
    wire [`PECNT_DATA_W-1:0] cnt_pad = '0;
    wire [`PECNT_DATA_W-1:0] rd_mux =
        hit_rxe ? {cnt_pad[15:8], rxe_cnt} :
        hit_fc ? {cnt_pad[15:8], fc_cnt} :
        hit_drop ? {cnt_pad[15:8], drop_cnt} :
        hit_ten ? ten_ctrl_reg :
        hit_ext ? ext_ctrl_reg :
        hit_ist ? {cnt_pad[15:3], irq_stat_reg} :
        hit_imk ? {cnt_pad[15:3], irq_mask_reg} : cnt_pad;

    // ****************************************
    // output registers
    // ****************************************
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
            link_integrity_dis <= 1'b0;
            jabber_dis <= 1'b0;
            echo_dis <= 1'b1;
            sqe_test_dis <= 1'b1;
            squelch_sel <= 2'h0;
            carrier_sense <= 1'b0;
            far_end_loopback <= 1'b0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_rdata <= reg_rd ? rd_mux : '0;
            link_integrity_dis <= ten_ctrl_reg[`PECNT_BIT_LINK_INT_DIS];
            jabber_dis <= ten_ctrl_reg[`PECNT_BIT_JABBER_DIS];
            echo_dis <= ten_ctrl_reg[`PECNT_BIT_ECHO_DIS];
            sqe_test_dis <= ten_ctrl_reg[`PECNT_BIT_SQE_DIS];
            squelch_sel <=
                ten_ctrl_reg[`PECNT_SQUELCH_HI:`PECNT_SQUELCH_LO];
            carrier_sense <= crs_next;
            far_end_loopback <= ext_ctrl_reg[`PECNT_BIT_FAR_LOOP];
            irq <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_rxe_needs_link;
        @(posedge mclk) disable iff (rst)
        (clk_en && !fast_link_up && !(reg_rd && hit_rxe))
            |=> (rxe_cnt == $past(rxe_cnt));
    endproperty
    a_rxe_needs_link: assert property (p_rxe_needs_link)
        else $error("rx error count moved with link down");

    property p_fc_needs_link;
        @(posedge mclk) disable iff (rst)
        (clk_en && !fast_link_up && !(reg_rd && hit_fc))
            |=> (fc_cnt == $past(fc_cnt));
    endproperty
    a_fc_needs_link: assert property (p_fc_needs_link)
        else $error("false carrier count moved with link down");

    property p_read_returns;
        @(posedge mclk) disable iff (rst)
        (clk_en && reg_rd && hit_drop) |=> (reg_rdata[7:0] == $past(drop_cnt));
    endproperty
    a_read_returns: assert property (p_read_returns)
        else $error("counter read returned wrong value");

    property p_drop_counts;
        @(posedge mclk) disable iff (rst)
        (clk_en && drop_ev && !reg_rd && drop_cnt != `PECNT_CNT_MAX)
            |=> (drop_cnt == $past(drop_cnt) + `PECNT_CNT_ONE);
    endproperty
    a_drop_counts: assert property (p_drop_counts)
        else $error("link drop not counted");

    property p_ten_ctrl_out;
        @(posedge mclk) disable iff (rst)
        (clk_en && reg_wr && hit_ten) ##1 clk_en |=>
            (jabber_dis == $past(reg_wdata[14], 2)
            && link_integrity_dis == $past(reg_wdata[15], 2));
    endproperty
    a_ten_ctrl_out: assert property (p_ten_ctrl_out)
        else $error("10M control outputs wrong after write");

    property p_reserved_zero;
        @(posedge mclk) disable iff (rst)
        (clk_en && reg_rd && hit_ext) |=>
            (reg_rdata[15:4] == 12'h000 && reg_rdata[2:0] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_sq_dis_reset;
        @(posedge mclk) $fell(rst) |-> (echo_dis && sqe_test_dis);
    endproperty
    a_sq_dis_reset: assert property (p_sq_dis_reset)
        else $error("echo or sqe disable not set after reset");

    property p_crs_rx;
        @(posedge mclk) disable iff (rst)
        (clk_en && crs_sel == pecnt_pkg::PECNT_CRS_RX) |=>
            (!clk_en || carrier_sense == $past(s_rxing));
    endproperty
    a_crs_rx: assert property (p_crs_rx)
        else $error("carrier sense not following receive");

    property p_squelch;
        @(posedge mclk) disable iff (rst)
        clk_en |=> (!clk_en || squelch_sel == $past(ten_ctrl_reg[11:10]));
    endproperty
    a_squelch: assert property (p_squelch)
        else $error("squelch select not from control");

endmodule

`default_nettype wire

/* test/pecnt_link_partner.sv */
/*
 * remote link partner: turns bench requests into line-side status pins.
 * assumes: err_req and fc_req are one-cycle pulses on mclk from the bench; link_req is a held level.
 */
`timescale 1ns/100ps
`default_nettype none

module pecnt_link_partner (
    // clock
    input wire logic mclk,
    // requests from bench
    input wire logic err_req,
    input wire logic fc_req,
    input wire logic [2:0] link_req,
    // status pins to phy
    output var logic rx_err_toggle,
    output var logic false_carrier_toggle,
    output logic link_up_100,
    output logic link_up_1000,
    output logic link_up_any
);
    initial
    begin
        rx_err_toggle = 1'b0;
        false_carrier_toggle = 1'b0;
    end

    // one flip per event, off the bench clock edge
    always @(posedge mclk)
    begin
        if (err_req)
            rx_err_toggle <= #1.3 ~rx_err_toggle;
        if (fc_req)
            false_carrier_toggle <= #1.3 ~false_carrier_toggle;
    end

    // link_req: bit 0 10M, bit 1 100M, bit 2 1000M
    assign link_up_100 = link_req[1];
    assign link_up_1000 = link_req[2];
    assign link_up_any = |link_req;
endmodule

`default_nettype wire

/* test/tb_phy_error_counters_and_ten_base_control.sv */
/*
 * self-checking bench for the error counter and 10 Mb/s control group.
 * assumes: design files and the link partner model are compiled first.
 */
`include "pecnt_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_phy_error_counters_and_ten_base_control;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic receiving = 1'b0;
    logic transmitting = 1'b0;
    logic full_duplex_flag = 1'b0;
    logic err_req = 1'b0;
    logic fc_req = 1'b0;
    logic [2:0] link_req = 3'h0;
    logic [15:0] reg_rdata;
    logic rx_err_toggle, false_carrier_toggle;
    logic link_up_100, link_up_1000, link_up_any;
    logic link_integrity_dis, jabber_dis, echo_dis, sqe_test_dis;
    logic [1:0] squelch_sel;
    logic carrier_sense, far_end_loopback, irq;
    wire logic [15:0] outs;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    assign outs = {7'h00, link_integrity_dis, jabber_dis, echo_dis,
        sqe_test_dis, squelch_sel, far_end_loopback, carrier_sense, irq};

    always #2.5 mclk = ~mclk;

    pecnt_top dut (
        .mclk(mclk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_err_toggle(rx_err_toggle),
        .false_carrier_toggle(false_carrier_toggle),
        .link_up_100(link_up_100), .link_up_1000(link_up_1000),
        .link_up_any(link_up_any), .receiving(receiving),
        .transmitting(transmitting), .full_duplex_flag(full_duplex_flag),
        .link_integrity_dis(link_integrity_dis), .jabber_dis(jabber_dis),
        .echo_dis(echo_dis), .sqe_test_dis(sqe_test_dis),
        .squelch_sel(squelch_sel), .carrier_sense(carrier_sense),
        .far_end_loopback(far_end_loopback), .irq(irq)
    );

    pecnt_link_partner partner (
        .mclk(mclk), .err_req(err_req), .fc_req(fc_req),
        .link_req(link_req), .rx_err_toggle(rx_err_toggle),
        .false_carrier_toggle(false_carrier_toggle),
        .link_up_100(link_up_100), .link_up_1000(link_up_1000),
        .link_up_any(link_up_any)
    );

    // ****************************************
    // bus and check helpers
    // ****************************************
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // data stand in the cycle after the strobe only
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        rd(a, q);
        chk(q, e);
    endtask

    task automatic pulse_ev(input logic fc, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            err_req <= ~fc;
            fc_req <= fc;
            @(posedge mclk);
            err_req <= 1'b0;
            fc_req <= 1'b0;
            cyc(3);
        end
        cyc(4);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rdc(`PECNT_IDX_RX_ERR, 16'h0000);
        rdc(`PECNT_IDX_FALSE_CARRIER, 16'h0000);
        rdc(`PECNT_IDX_LINK_DROP, 16'h0000);
        rdc(`PECNT_IDX_TEN_CTRL, 16'h3000);
        rdc(`PECNT_IDX_EXT_CTRL1, 16'h0000);
        chk(outs, 16'h0060);
        $display("test reset done");
    endtask

    task automatic t_ctrl;
        wr(`PECNT_IDX_TEN_CTRL, 16'hFFFF);
        rdc(`PECNT_IDX_TEN_CTRL, 16'hFC06);
        wr(`PECNT_IDX_EXT_CTRL1, 16'hFFFF);
        rdc(`PECNT_IDX_EXT_CTRL1, 16'h0008);
        cyc(2);
        chk(outs, 16'h01FC);
        wr(`PECNT_IDX_EXT_CTRL1, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(`PECNT_IDX_TEN_CTRL, {4'h0, 2'(i), 10'h000});
            rdc(`PECNT_IDX_TEN_CTRL, {4'h0, 2'(i), 10'h000});
            cyc(2);
            chk(outs, {11'h000, 2'(i), 3'h0});
        end
        wr(5'h00, 16'hFFFF);
        rdc(5'h00, 16'h0000);
        rdc(5'h1F, 16'h0000);
        $display("test control done");
    endtask

    task automatic t_crs;
        logic r, t, f, e;
        for (int s = 0; s < 4; s++)
        begin
            wr(`PECNT_IDX_TEN_CTRL, {6'h0C, 7'h00, 2'(s), 1'b0});
            for (int v = 0; v < 8; v++)
            begin
                {r, t, f} = 3'(v);
                @(posedge mclk);
                receiving <= r;
                transmitting <= t;
                full_duplex_flag <= f;
                cyc(6);
                case (s)
                    0: e = r | (t & ~f);
                    1: e = (r | t) & ~f;
                    2: e = r;
                    default: e = r & ~f;
                endcase
                chk({15'h0000, carrier_sense}, {15'h0000, e});
            end
        end
        $display("test carrier sense done");
    endtask

    task automatic t_count;
        link_req <= 3'b010;
        pulse_ev(1'b0, 3);
        rdc(`PECNT_IDX_RX_ERR, 16'h0003);
        rdc(`PECNT_IDX_RX_ERR, 16'h0000);
        link_req <= 3'b100;
        pulse_ev(1'b1, 2);
        pulse_ev(1'b0, 2);
        rdc(`PECNT_IDX_FALSE_CARRIER, 16'h0002);
        rdc(`PECNT_IDX_FALSE_CARRIER, 16'h0000);
        rdc(`PECNT_IDX_RX_ERR, 16'h0002);
        link_req <= 3'b001;
        pulse_ev(1'b0, 2);
        pulse_ev(1'b1, 2);
        rdc(`PECNT_IDX_RX_ERR, 16'h0000);
        rdc(`PECNT_IDX_FALSE_CARRIER, 16'h0000);
        rdc(`PECNT_IDX_LINK_DROP, 16'h0000);
        link_req <= 3'b000;
        cyc(6);
        link_req <= 3'b100;
        cyc(6);
        link_req <= 3'b000;
        cyc(6);
        rdc(`PECNT_IDX_LINK_DROP, 16'h0002);
        link_req <= 3'b010;
        pulse_ev(1'b0, 257);
        rdc(`PECNT_IDX_RX_ERR, 16'h00FF);
        rdc(`PECNT_IDX_RX_ERR, 16'h0000);
        $display("test counters done");
    endtask

    // event landing at every offset around the clearing read is never lost
    task automatic t_coincide;
        logic [15:0] a, b;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge mclk);
            err_req <= 1'b1;
            @(posedge mclk);
            err_req <= 1'b0;
            cyc(k);
            rd(`PECNT_IDX_RX_ERR, a);
            cyc(8);
            rd(`PECNT_IDX_RX_ERR, b);
            chk(a + b, 16'h0001);
        end
        $display("test coincide done");
    endtask

    task automatic t_irq;
        wr(`PECNT_IDX_IRQ_STATUS, 16'h0007);
        wr(`PECNT_IDX_IRQ_MASK, 16'h0001);
        cyc(2);
        chk(outs, 16'h0060);
        pulse_ev(1'b0, 1);
        chk(outs, 16'h0061);
        rdc(`PECNT_IDX_IRQ_STATUS, 16'h0001);
        wr(`PECNT_IDX_IRQ_STATUS, 16'h0001);
        cyc(2);
        chk(outs, 16'h0060);
        pulse_ev(1'b1, 1);
        chk(outs, 16'h0060);
        rdc(`PECNT_IDX_IRQ_STATUS, 16'h0002);
        rdc(`PECNT_IDX_RX_ERR, 16'h0001);
        rdc(`PECNT_IDX_FALSE_CARRIER, 16'h0001);
        $display("test interrupt done");
    endtask

    // a write while the clock enable is low is not taken
    task automatic t_freeze;
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(`PECNT_IDX_TEN_CTRL, 16'hFFFF);
        clk_en <= 1'b1;
        rdc(`PECNT_IDX_TEN_CTRL, 16'h3006);
        $display("test clock enable done");
    endtask

    // mid-run reset with toggle pins left high and link up
    task automatic t_rerst;
        @(posedge mclk);
        receiving <= 1'b0;
        transmitting <= 1'b0;
        full_duplex_flag <= 1'b0;
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        t_reset();
        pulse_ev(1'b0, 1);
        rdc(`PECNT_IDX_RX_ERR, 16'h0001);
        $display("test mid-run reset done");
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        cyc(3);
        rst <= 1'b0;
        t_reset();
        t_ctrl();
        t_crs();
        t_count();
        t_coincide();
        t_irq();
        t_freeze();
        t_rerst();
        end_of_test();
    end
endmodule

`default_nettype wire
